// ---- ecr_regs.sv ----
// serial-link capability register bank with an axi4-lite slave
// Function
// R1 - slot implemented reads 1 only in reverse mode; message number zero
// R2 - supported payload field read-only, reset 010
// R3 - no phantom functions; 8-bit tag supported bit reads one
// R4 - acceptable L0s latency read-only, reads 000
// R5 - acceptable L1 latency read-only, reads 000
// R6 - device hot-plug presence bits set only with strap in forward mode
// R7 - slot power limit message value and scale captured, read-only
// R8 - four error reporting enables read-write, reset zero
// R9 - max payload control field read-write, reset 000
// R10 - max read request field read-write, reset 2h
// R11 - relaxed, phantom, aux, no-snoop read zero; ext tag, retry RW
// R12 - error detected flags write-one-clear; aux power 1; pending live
// R13 - link speed 0001 and width 000100 advertised
// R14 - both ASPM states supported; exit latencies 3h and 0h
// R15 - ASPM control field read-write, reset 00, driven out
// R16 - link disable, retrain read-only in forward mode; clock bits RW
// R17 - link status speed 1h, width 000100, slot clock reads 1
// R18 - slot hot-plug presence bits set only with strap in reverse mode
// R19 - slot control enables and indicator controls read-write, reset 0
// R20 - tuning 0 enables and counts read-write with their resets
// R21 - tuning 1 lifetime timers read-write, reset 04000271h
// R22 - tuning 2 recovery time and exit latencies read-write
// R23 - port type reads 7h forward, 8h reverse
// R24 - reserved bits read zero; read-only bits ignore writes
// R25 - slot status bits read-only, follow hot-plug inputs
module ecr_regs (
    input wire logic mclk,
    input wire logic reset,
    input wire logic reverse_mode,
    input wire logic hotplug_strap,
    input wire logic power_limit_valid,
    input wire logic [7:0] power_limit_value,
    input wire logic [1:0] power_limit_scale,
    input wire logic [3:0] error_detect,
    input wire logic txn_pending,
    input wire logic [6:0] slot_events,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] port_type,
    output logic [1:0] aspm_control,
    output logic [2:0] max_payload,
    output logic [2:0] max_read_req,
    output logic link_disable,
    output logic retrain_link,
    output logic slot_implemented
);
    import ecr_pkg::*;

    // strap and mode pins pass three flops; a change counts on agreement
    logic [2:0] rev_sync_reg, hp_sync_reg;
    logic rev_reg, hp_reg;
    logic [3:0] err_sync1_reg, err_sync2_reg;
    logic pend_sync1_reg, pend_sync2_reg;
    logic [6:0] slot_sync1_reg, slot_sync2_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rev_sync_reg <= 3'h0;
            hp_sync_reg <= 3'h0;
            rev_reg <= 1'b0;
            hp_reg <= 1'b0;
        end else begin
            rev_sync_reg <= {rev_sync_reg[1:0], reverse_mode};
            hp_sync_reg <= {hp_sync_reg[1:0], hotplug_strap};
            if (rev_sync_reg[1] == rev_sync_reg[2]) begin
                rev_reg <= rev_sync_reg[2];
            end
            if (hp_sync_reg[1] == hp_sync_reg[2]) begin
                hp_reg <= hp_sync_reg[2];
            end
        end
    end

    // error, pending and slot inputs come from core logic on mclk; two stages each
    always_ff @(posedge mclk) begin
        if (reset) begin
            err_sync1_reg <= 4'h0;
            err_sync2_reg <= 4'h0;
            pend_sync1_reg <= 1'b0;
            pend_sync2_reg <= 1'b0;
            slot_sync1_reg <= 7'h00;
            slot_sync2_reg <= 7'h00;
        end else begin
            err_sync1_reg <= error_detect;
            err_sync2_reg <= err_sync1_reg;
            pend_sync1_reg <= txn_pending;
            pend_sync2_reg <= pend_sync1_reg;
            slot_sync1_reg <= slot_events;
            slot_sync2_reg <= slot_sync1_reg;
        end
    end

    // axi write channel: address and data may arrive in either order
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready;
            s_axi_wready <= !w_held_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
        end
    end

    function automatic logic addr_ok(input logic [7:0] a);
        return a[1:0] == 2'h0 && a >= ADDR_DEV_CAP && a <= ADDR_TUNE2;
    endfunction

    // merge write data with byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] dev_ctl_w, lnk_ctl_w, slt_ctl_w, t0_w, t1_w, t2_w;
    logic [15:0] dev_ctl_reg, lnk_ctl_reg, slt_ctl_reg;
    logic [31:0] tune0_reg, tune1_reg, tune2_reg;
    logic [3:0] err_flag_reg;
    logic [7:0] plim_val_reg;
    logic [1:0] plim_scl_reg;
    assign dev_ctl_w = merge({16'h0, dev_ctl_reg}, w_data_reg, w_strb_reg);
    assign lnk_ctl_w = merge({16'h0, lnk_ctl_reg}, w_data_reg, w_strb_reg);
    assign slt_ctl_w = merge({16'h0, slt_ctl_reg}, w_data_reg, w_strb_reg);
    assign t0_w = merge(tune0_reg, w_data_reg, w_strb_reg);
    assign t1_w = merge(tune1_reg, w_data_reg, w_strb_reg);
    assign t2_w = merge(tune2_reg, w_data_reg, w_strb_reg);

    // device control: only writable fields are stored, rest read zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            dev_ctl_reg <= {1'b0, MRRS_RESET, 4'h0, MPS_RESET, 5'h00};
        end else if (wr_fire && aw_addr_reg == ADDR_DEV_CTL) begin
            // R8 error enables
            dev_ctl_reg[3:0] <= dev_ctl_w[3:0];
            // R9 payload control
            dev_ctl_reg[7:5] <= dev_ctl_w[7:5];
            // R11 tag and retry
            dev_ctl_reg[8] <= dev_ctl_w[8];
            dev_ctl_reg[15] <= dev_ctl_w[15];
            // R10 read request size
            dev_ctl_reg[14:12] <= dev_ctl_w[14:12];
        end
    end

    // R12 write-one clear; a new detect in the same cycle wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            err_flag_reg <= 4'h0;
        end else begin
            if (wr_fire && aw_addr_reg == ADDR_DEV_CTL && w_strb_reg[2]) begin
                err_flag_reg <= (err_flag_reg & ~w_data_reg[19:16])
                    | err_sync2_reg;
            end else begin
                err_flag_reg <= err_flag_reg | err_sync2_reg;
            end
        end
    end

    // R7 capture power limit message
    always_ff @(posedge mclk) begin
        if (reset) begin
            plim_val_reg <= 8'h00;
            plim_scl_reg <= 2'h0;
        end else if (power_limit_valid) begin
            plim_val_reg <= power_limit_value;
            plim_scl_reg <= power_limit_scale;
        end
    end

    // link and slot control
    always_ff @(posedge mclk) begin
        if (reset) begin
            lnk_ctl_reg <= 16'h0;
            slt_ctl_reg <= 16'h0;
        end else if (wr_fire) begin
            if (aw_addr_reg == ADDR_LNK_CTL) begin
                // R15 aspm control
                lnk_ctl_reg[1:0] <= lnk_ctl_w[1:0];
                // R16 disable and retrain writable only in reverse
                if (rev_reg) begin
                    lnk_ctl_reg[5:4] <= lnk_ctl_w[5:4];
                end
                lnk_ctl_reg[7:6] <= lnk_ctl_w[7:6];
            end else if (aw_addr_reg == ADDR_SLT_CTL) begin
                // R19 slot control bits
                slt_ctl_reg[10:0] <= slt_ctl_w[10:0];
            end
        end
    end

    // tuning registers; reserved bits never stored
    always_ff @(posedge mclk) begin
        if (reset) begin
            tune0_reg <= {L1_ENTRY_RESET, 3'h0, TS1_COUNT_RESET,
                NEG_RETRY_RESET, 5'h00};
            tune1_reg <= TUNE1_RESET;
            tune2_reg <= {9'h000, L1_EXIT_RESET, 1'b0, L0S_EXIT_RESET,
                CLK_RECOVERY_RESET};
        end else if (wr_fire) begin
            // R20 tuning 0
            if (aw_addr_reg == ADDR_TUNE0) begin
                tune0_reg <= {t0_w[31:16], 3'h0, t0_w[12:0]};
            // R21 tuning 1
            end else if (aw_addr_reg == ADDR_TUNE1) begin
                tune1_reg <= {t1_w[31:16], 6'h00, t1_w[9:0] & TUNE1_LO_MASK};
            // R22 tuning 2
            end else if (aw_addr_reg == ADDR_TUNE2) begin
                tune2_reg <= {9'h000, t2_w[22:16], 1'b0, t2_w[14:0]};
            end
        end
    end

    // read data assembly
    logic fwd_hp, rev_hp;
    logic [31:0] rd_word;
    assign fwd_hp = hp_reg && !rev_reg;
    assign rev_hp = hp_reg && rev_reg;

    always_comb begin
        rd_word = 32'h0;
        if (s_axi_araddr == ADDR_DEV_CAP) begin
            // R2 R3 R4 R5 R6 R7 fixed and captured fields
            rd_word = {4'h0, plim_scl_reg, plim_val_reg, 3'h0,
                fwd_hp, fwd_hp, fwd_hp, 3'h0, 3'h0, 1'b1, 2'h0,
                MPS_SUPPORTED};
        end else if (s_axi_araddr == ADDR_DEV_CTL) begin
            // R12 aux power reads one, pending follows the core
            rd_word = {10'h000, pend_sync2_reg, 1'b1, err_flag_reg,
                dev_ctl_reg};
        end else if (s_axi_araddr == ADDR_LNK_CAP) begin
            // R13 R14 link capability
            rd_word = {14'h0000, L1_EXIT_LAT, L0S_EXIT_LAT, ASPM_SUPPORT,
                LINK_WIDTH, LINK_SPEED};
        end else if (s_axi_araddr == ADDR_LNK_CTL) begin
            // R17 link status
            rd_word = {3'h0, 1'b1, 2'h0, LINK_WIDTH, LINK_SPEED,
                lnk_ctl_reg};
        end else if (s_axi_araddr == ADDR_SLT_CAP) begin
            // R18 slot presence bits
            rd_word = {25'h0000000, rev_hp, 1'b0, rev_hp, rev_hp, rev_hp,
                1'b0, rev_hp};
        end else if (s_axi_araddr == ADDR_SLT_CTL) begin
            // R25 slot status mirrors hot-plug inputs
            rd_word = {9'h000, slot_sync2_reg, slt_ctl_reg};
        end else if (s_axi_araddr == ADDR_TUNE0) begin
            rd_word = tune0_reg;
        end else if (s_axi_araddr == ADDR_TUNE1) begin
            rd_word = tune1_reg;
        end else if (s_axi_araddr == ADDR_TUNE2) begin
            rd_word = tune2_reg;
        end
    end

    // read channel: one-cycle accept, data registered
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                // R24 unmapped reads zero with slverr
                s_axi_rdata <= rd_word;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control outputs toward the core
    always_ff @(posedge mclk) begin
        if (reset) begin
            port_type <= 4'h7;
            aspm_control <= 2'h0;
            max_payload <= MPS_RESET;
            max_read_req <= MRRS_RESET;
            link_disable <= 1'b0;
            retrain_link <= 1'b0;
            slot_implemented <= 1'b0;
        end else begin
            // R23 port type follows mode; R1 slot bit alongside
            port_type <= rev_reg ? 4'h8 : 4'h7;
            aspm_control <= lnk_ctl_reg[1:0];
            max_payload <= dev_ctl_reg[7:5];
            max_read_req <= dev_ctl_reg[14:12];
            link_disable <= lnk_ctl_reg[4];
            retrain_link <= lnk_ctl_reg[5];
            // R1 slot bit follows mode
            slot_implemented <= rev_reg;
        end
    end

    // R12 a detect sets its flag on the next cycle
    flag_sticky_a: assert property (@(posedge mclk) disable iff (reset) // R12
        err_sync2_reg[0] |=> err_flag_reg[0])
        else $error("error flag lost its detect");
    // R12 write one clears when no new detect
    flag_clear_a: assert property (@(posedge mclk) disable iff (reset) // R12
        wr_fire && aw_addr_reg == ADDR_DEV_CTL && w_strb_reg[2]
        && w_data_reg[16] && !err_sync2_reg[0] |=> !err_flag_reg[0])
        else $error("error flag not cleared by write one");
    // R16 forward mode locks link disable
    fwd_lock_a: assert property (@(posedge mclk) disable iff (reset) // R16
        !rev_reg && $stable(rev_reg) |=> $stable(lnk_ctl_reg[4]))
        else $error("link disable changed in forward mode");
    // R1 slot implemented follows mode
    slot_impl_a: assert property (@(posedge mclk) disable iff (reset) // R1
        1'b1 |=> slot_implemented == $past(rev_reg))
        else $error("slot implemented does not follow mode");
    // R23 port type follows mode
    port_type_a: assert property (@(posedge mclk) disable iff (reset) // R23
        1'b1 |=> port_type == ($past(rev_reg) ? 4'h8 : 4'h7))
        else $error("port type does not follow mode");
    // R6 device presence bits read back
    dev_hp_a: assert property (@(posedge mclk) disable iff (reset) // R6
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_DEV_CAP
        |=> s_axi_rdata[14:12] == {3{$past(fwd_hp)}})
        else $error("device presence bits read back wrong");
    // R24 refused writes answer slverr; a reason: no silent drops
    sequence bad_wr_s;
        wr_fire && !addr_ok(aw_addr_reg);
    endsequence
    sequence slverr_s;
        s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endsequence
    bad_write_a: assert property (@(posedge mclk) disable iff (reset) // R24
        bad_wr_s |=> slverr_s)
        else $error("refused write not answered with slverr");
endmodule

// ---- ecr_pkg.sv ----
// constants for the serial-link capability register bank
package ecr_pkg;
    localparam logic [7:0] ADDR_DEV_CAP = 8'hb4;
    localparam logic [7:0] ADDR_DEV_CTL = 8'hb8;
    localparam logic [7:0] ADDR_LNK_CAP = 8'hbc;
    localparam logic [7:0] ADDR_LNK_CTL = 8'hc0;
    localparam logic [7:0] ADDR_SLT_CAP = 8'hc4;
    localparam logic [7:0] ADDR_SLT_CTL = 8'hc8;
    localparam logic [7:0] ADDR_TUNE0 = 8'hcc;
    localparam logic [7:0] ADDR_TUNE1 = 8'hd0;
    localparam logic [7:0] ADDR_TUNE2 = 8'hd4;
    localparam logic [2:0] MPS_SUPPORTED = 3'h2;
    localparam logic [2:0] MPS_RESET = 3'h0;
    localparam logic [2:0] MRRS_RESET = 3'h2;
    localparam logic [3:0] LINK_SPEED = 4'h1;
    localparam logic [5:0] LINK_WIDTH = 6'h04;
    localparam logic [1:0] ASPM_SUPPORT = 2'h3;
    localparam logic [2:0] L0S_EXIT_LAT = 3'h3;
    localparam logic [2:0] L1_EXIT_LAT = 3'h0;
    localparam logic [2:0] NEG_RETRY_RESET = 3'h3;
    localparam logic [4:0] TS1_COUNT_RESET = 5'h10;
    localparam logic [15:0] L1_ENTRY_RESET = 16'h0400;
    localparam logic [31:0] TUNE1_RESET = 32'h04000271;
    localparam logic [7:0] CLK_RECOVERY_RESET = 8'h54;
    localparam logic [6:0] L0S_EXIT_RESET = 7'h02;
    localparam logic [6:0] L1_EXIT_RESET = 7'h19;
    localparam logic [9:0] TUNE1_LO_MASK = 10'h3ff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- ecr_host.sv ----
// host-side axi4-lite master model for the register bank
module ecr_host (
    input wire mclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready,
    output logic hung
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, hung} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
        s_axi_wdata = 32'h0;
    end
    // each channel holds until its own ready; the wait is bounded
    task automatic write(input logic [7:0] a, input logic [31:0] v,
            input logic [3:0] s, output logic [1:0] r);
        logic got;
        got = 1'b0;
        r = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 64 && !got; n++) begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                got = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
        hung = !got;
        // spare edge so the next request never reassigns in this step
        @(posedge mclk);
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] v,
            output logic [1:0] r);
        logic got;
        got = 1'b0;
        r = 2'h3;
        v = 32'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 64 && !got; n++) begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                v = s_axi_rdata;
                r = s_axi_rresp;
                got = 1'b1;
            end
        end
        s_axi_rready <= 1'b0;
        hung = !got;
        @(posedge mclk);
    endtask
endmodule

// ---- express_capability_regs_test.sv ----
// self-checking bench for the capability register bank
module express_capability_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, reset = 1'b1, reverse_mode = 1'b0;
    logic hotplug_strap = 1'b0, power_limit_valid = 1'b0;
    logic txn_pending = 1'b0;
    logic [7:0] power_limit_value = 8'h00;
    logic [1:0] power_limit_scale = 2'h0;
    logic [3:0] error_detect = 4'h0;
    logic [6:0] slot_events = 7'h00;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, port_type;
    logic [1:0] s_axi_bresp, s_axi_rresp, aspm_control, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, link_disable, retrain_link, hung;
    logic slot_implemented;
    logic [2:0] max_payload, max_read_req;
    int fail_count = 0, checked = 0;
    logic [7:0] adr [9] = '{8'hb4, 8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hc8,
        8'hcc, 8'hd0, 8'hd4};
    logic [31:0] rst_v [9] = '{32'h22, 32'h102000, 32'h3c41,
        32'h10410000, 32'h0, 32'h0, 32'h04001060, 32'h04000271,
        32'h00190254};
    logic [31:0] one_v [9] = '{32'h22, 32'h0010f1ef, 32'h3c41,
        32'h104100c3, 32'h0, 32'h7ff, 32'hffff1fff, 32'hffff03ff,
        32'h007f7fff};
    ecr_regs DUT (
        .mclk, .reset, .reverse_mode, .hotplug_strap, .power_limit_valid,
        .power_limit_value, .power_limit_scale, .error_detect, .txn_pending,
        .slot_events, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_type, .aspm_control,
        .max_payload, .max_read_req, .link_disable, .retrain_link,
        .slot_implemented
    );
    ecr_host host (
        .mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .hung
    );
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic guard;
        if (hung) begin
            fail_count++;
            test_done;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
            input logic [3:0] s);
        host.write(a, v, s, r);
        guard;
    endtask
    task automatic rd(input logic [7:0] a);
        host.read(a, d, r);
        guard;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 9; i++) begin
            rd(adr[i]);
            chk("reset word", d, rst_v[i]);
        end
        chk("port type", 32'(port_type), 32'h7);
        chk("slot impl", 32'(slot_implemented), 32'h0);
        chk("read req out", 32'(max_read_req), 32'h2);
    endtask
    // all ones everywhere: only the writable bits may stick
    task automatic t_rw;
        for (int i = 0; i < 9; i++) begin
            wr(adr[i], 32'hffffffff, 4'hf);
            chk("write resp", 32'(r), 32'h0);
            rd(adr[i]);
            chk("rw word", d, one_v[i]);
        end
        chk("ctl outs", 32'({aspm_control, max_payload, max_read_req,
            link_disable, retrain_link}), 32'h3fc);
        wr(8'hb8, 32'h0, 4'h3);
    endtask
    task automatic t_strobe;
        wr(8'hd0, 32'h0, 4'h2);
        rd(8'hd0);
        chk("byte strobe", d, 32'hffff00ff);
    endtask
    task automatic t_bad;
        wr(8'hd8, 32'hffffffff, 4'hf);
        chk("unmapped wr", 32'(r), 32'h2);
        rd(8'hd8);
        chk("unmapped rd", {d[29:0], r}, 32'h2);
        wr(8'hce, 32'h0, 4'hf);
        rd(8'hcc);
        chk("unaligned wr", d, 32'hffff1fff);
    endtask
    task automatic t_status;
        error_detect <= 4'hf;
        txn_pending <= 1'b1;
        @(posedge mclk);
        error_detect <= 4'h0;
        cyc(4);
        rd(8'hb8);
        chk("err flags", 32'(d[21:16]), 32'h3f);
        wr(8'hb8, 32'h00050000, 4'h4);
        rd(8'hb8);
        chk("err clear", 32'(d[21:16]), 32'h3a);
        txn_pending <= 1'b0;
    endtask
    // inputs drop after the pulse, so only a capture can show them
    task automatic t_power;
        power_limit_value <= 8'ha5;
        power_limit_scale <= 2'h2;
        power_limit_valid <= 1'b1;
        @(posedge mclk);
        {power_limit_valid, power_limit_value, power_limit_scale} <= 11'h0;
        cyc(2);
        wr(8'hb4, 32'h0, 4'hf);
        rd(8'hb4);
        chk("power limit", d, 32'h0a940022);
    endtask
    task automatic t_mode;
        reverse_mode <= 1'b1;
        hotplug_strap <= 1'b1;
        slot_events <= 7'h55;
        cyc(10);
        chk("rev port type", 32'(port_type), 32'h8);
        chk("rev slot impl", 32'(slot_implemented), 32'h1);
        rd(8'hc4);
        chk("rev slot cap", d, 32'h5d);
        rd(8'hb4);
        chk("rev dev cap", d, 32'h0a940022);
        rd(8'hc8);
        chk("slot status", d, 32'h005507ff);
        wr(8'hc0, 32'h30, 4'h1);
        rd(8'hc0);
        chk("rev link ctl", d, 32'h10410030);
        chk("link outs", 32'({link_disable, retrain_link}), 32'h3);
        reverse_mode <= 1'b0;
        cyc(10);
        chk("fwd slot impl", 32'(slot_implemented), 32'h0);
        rd(8'hb4);
        chk("fwd dev cap", d, 32'h0a947022);
        rd(8'hc4);
        chk("fwd slot cap", d, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        cyc(8);
        t_reset;
        t_rw;
        t_strobe;
        t_bad;
        t_status;
        t_power;
        t_mode;
        test_done;
    end
endmodule
